// *** pst_core.sv ***
`timescale 1ns/100ps
module pst_core #(
	parameter int N_IRQ = 4,
	parameter int IW = 2
) (
	input wire logic clk_i, // 25 MHz clock.
	input wire logic reset_n_i, // Async reset.
	input wire pst_pkg::pst_alu_t alu_i, // Result operands.
	input wire logic psw_wr_i, // User word write.
	input wire logic [15:0] psw_data_i, // User word data.
	input wire logic exc_req_i, // Exception raised.
	input wire logic [8:0] exc_off_i, // Exception vector offset.
	input wire logic chm_req_i, // Change mode trap.
	input wire pst_pkg::pst_mode_t chm_mode_i, // Target mode.
	input wire logic [N_IRQ-1:0] irq_req_i, // Controller requests.
	input wire logic [N_IRQ-1:0] irq_en_i, // Driver enables.
	input wire logic [N_IRQ*5-1:0] irq_lvl_i, // Levels.
	input wire logic vec_ack_i, // Vector read done.
	input wire logic [31:0] vec_data_i, // Vector contents.
	input wire logic rei_i, // Return instruction.
	input wire logic [31:0] rei_pc_i, // Popped counter.
	input wire pst_pkg::pst_psl_t rei_psl_i, // Popped status.
	input wire logic priv_op_i, // Kernel-only operation.
	input wire logic scbb_wr_i, // Base register write.
	input wire logic [31:0] scbb_data_i, // Base value.
	input wire logic probe_i, // Probe request.
	input wire pst_pkg::pst_mode_t probe_min_i, // Least mode allowed.
	input wire pst_pkg::pst_lock_t lock_i, // Interlock control.
	input wire pst_pkg::pst_mem_t mem_i, // Plain access.
	output pst_pkg::pst_psl_t psl_o, // Status longword.
	output logic [31:0] pc_o, // Program counter.
	output logic vec_rd_o, // Vector read request.
	output logic [31:0] vec_addr_o, // Vector address.
	output logic irq_ack_o, // Interrupt taken.
	output logic [IW-1:0] irq_idx_o, // Source taken.
	output logic save_vld_o, // Saved pair valid.
	output logic [31:0] save_pc_o, // Counter to push.
	output pst_pkg::pst_psl_t save_psl_o, // Status to push.
	output logic priv_ok_o, // Kernel op allowed.
	output logic priv_fault_o, // Kernel op refused.
	output logic rei_fault_o, // Return refused.
	output logic probe_done_o, // Probe answered.
	output logic probe_ok_o, // Caller may access.
	output logic [2:0] sp_sel_o, // Stack pointer select.
	output logic lock_held_o, // Interlock held.
	output logic lock_grant_o, // Interlock granted.
	output logic lock_busy_o, // Retry later.
	output logic align_fault_o, // Misaligned interlock.
	output logic [3:0] mem_be_o, // Byte enables.
	output logic io_sel_o, // Device space access.
	output logic mem_vld_o // Access issued.
);

	// ***********************************************
	// State
	// ***********************************************
	typedef struct packed {
		pst_pkg::pst_psl_t processor_status_longword;
		logic [31:0] pc;
		logic [31:0] scbb;
		pst_pkg::pst_fsm_t st;
		logic vec_rd;
		logic [31:0] vec_addr;
		pst_pkg::pst_mode_t pend_mode;
		logic pend_is;
		logic [4:0] pend_ipl;
		logic irq_ack;
		logic [IW-1:0] irq_idx;
		logic [N_IRQ-1:0] irq_s1;
		logic [N_IRQ-1:0] irq_s2;
		logic save_vld;
		logic [31:0] save_pc;
		pst_pkg::pst_psl_t save_psl;
		logic priv_ok;
		logic priv_fault;
		logic rei_fault;
		logic probe_done;
		logic probe_ok;
		logic [2:0] sp_sel;
		logic lock_held;
		logic [7:0] lock_cnt;
		logic lock_grant;
		logic lock_busy;
		logic align_fault;
		logic [3:0] mem_be;
		logic io_sel;
		logic mem_vld;
	} pst_core_st_t;

	pst_core_st_t q;
	pst_core_st_t n;

	logic arb_vld;
	logic [4:0] arb_lvl;
	logic [IW-1:0] arb_idx;
	logic irq_take;
	logic [31:0] irq_off;
	logic [4:0] sh;
	logic [31:0] as;
	logic [31:0] bs;
	logic [32:0] sum;
	logic fl_c;
	logic fl_v;
	logic rei_ok;
	pst_pkg::pst_mode_t chm_tgt;
	pst_pkg::pst_mode_t caller;

	// ***********************************************
	// Interrupt arbitration
	// ***********************************************
	pst_irq_arb #(
		.N(N_IRQ),
		.LW(5),
		.IW(IW)
	) u_arb (
		.req_i(q.irq_s2),
		.en_i(irq_en_i),
		.lvl_i(irq_lvl_i),
		.valid_o(arb_vld),
		.lvl_o(arb_lvl),
		.idx_o(arb_idx)
	);

	// Only a strictly higher level preempts the running code.
	assign irq_take = arb_vld && (arb_lvl > q.processor_status_longword.ipl);
	assign irq_off = pst_pkg::IRQ_VEC_BASE + {28'h0000000, 2'(arb_idx), 2'h0};

	// ***********************************************
	// Condition code arithmetic
	// ***********************************************
	// Operands are moved to the top of the word so one adder serves
	// every size and the sign and carry flags always come from bit 31 and bit 32.
	assign sh = (alu_i.size == pst_pkg::SZ_BYTE) ? 5'h18 :
		(alu_i.size == pst_pkg::SZ_WORD) ? 5'h10 : 5'h00;
	assign as = alu_i.a << sh;
	assign bs = (alu_i.b << sh) ^ {32{alu_i.sub}};
	assign sum = {1'b0, as} + {1'b0, bs} + {32'h00000000, alu_i.sub};
	assign fl_c = sum[32] ^ alu_i.sub;
	assign fl_v = ((as[31] == bs[31]) && (sum[31] != as[31]))
		|| alu_i.conv_err;

	// A return may keep or lower privilege but never raise it, and it
	// may not select the interrupt stack from process context.
	assign rei_ok = (rei_psl_i.cur >= q.processor_status_longword.cur)
		&& (rei_psl_i.ipl <= q.processor_status_longword.ipl)
		&& (!rei_psl_i.is || q.processor_status_longword.is);

	// A change mode trap moves to the more privileged of the two.
	assign chm_tgt = (chm_mode_i < q.processor_status_longword.cur) ? chm_mode_i : q.processor_status_longword.cur;
	// The caller is the less privileged of current and previous mode.
	assign caller = (q.processor_status_longword.prv > q.processor_status_longword.cur) ? q.processor_status_longword.prv : q.processor_status_longword.cur;

	// ***********************************************
	// Next state
	// ***********************************************
	always_comb begin
		n = q;
		n.irq_s1 = irq_req_i;
		n.irq_s2 = q.irq_s1;
		n.irq_ack = 1'b0;
		n.save_vld = 1'b0;
		n.priv_ok = 1'b0;
		n.priv_fault = 1'b0;
		n.rei_fault = 1'b0;
		n.probe_done = 1'b0;
		n.probe_ok = 1'b0;
		n.lock_grant = 1'b0;
		n.lock_busy = 1'b0;
		n.align_fault = 1'b0;
		n.mem_vld = 1'b0;

		// Software may only touch the low half through this path.
		if (psw_wr_i) begin
			n.processor_status_longword[pst_pkg::PSW_W-1:0] = psw_data_i;
		end
		if (alu_i.valid) begin
			n.processor_status_longword.c = fl_c;
			n.processor_status_longword.n = sum[31];
			n.processor_status_longword.v = fl_v;
			n.processor_status_longword.z = (sum[31:0] == 32'h00000000);
		end

		// Kernel-only operations, base register writes included.
		if (priv_op_i || scbb_wr_i) begin
			if (q.processor_status_longword.cur == pst_pkg::MODE_KERNEL) begin
				n.priv_ok = 1'b1;
				if (scbb_wr_i) begin
					n.scbb = scbb_data_i;
				end
			end else begin
				n.priv_fault = 1'b1;
			end
		end

		// Probes answer from the mode table only and touch no memory.
		if (probe_i) begin
			n.probe_done = 1'b1;
			n.probe_ok = (caller <= probe_min_i);
		end

		unique case (q.st)
			pst_pkg::ST_IDLE: begin
				if (exc_req_i) begin
					n.vec_addr = q.scbb + {23'h000000, exc_off_i};
					n.pend_mode = pst_pkg::MODE_KERNEL;
					n.pend_is = q.processor_status_longword.is;
					n.pend_ipl = q.processor_status_longword.ipl;
					n.st = pst_pkg::ST_VEC;
					n.vec_rd = 1'b1;
				end else if (chm_req_i) begin
					n.vec_addr = q.scbb + pst_pkg::CHM_VEC_BASE
						+ {28'h0000000, 2'(chm_mode_i), 2'h0};
					n.pend_mode = chm_tgt;
					n.pend_is = q.processor_status_longword.is;
					n.pend_ipl = q.processor_status_longword.ipl;
					n.st = pst_pkg::ST_VEC;
					n.vec_rd = 1'b1;
				end else if (rei_i) begin
					if (rei_ok) begin
						n.pc = rei_pc_i;
						n.processor_status_longword = rei_psl_i;
					end else begin
						n.rei_fault = 1'b1;
					end
				end else if (irq_take) begin
					n.vec_addr = q.scbb + irq_off;
					n.pend_mode = pst_pkg::MODE_KERNEL;
					n.pend_is = 1'b1;
					n.pend_ipl = arb_lvl;
					n.irq_ack = 1'b1;
					n.irq_idx = arb_idx;
					n.st = pst_pkg::ST_VEC;
					n.vec_rd = 1'b1;
				end
			end
			pst_pkg::ST_VEC: begin
				// The old context is pushed when the handler starts.
				if (vec_ack_i) begin
					n.save_vld = 1'b1;
					n.save_pc = q.pc;
					n.save_psl = q.processor_status_longword;
					n.pc = {vec_data_i[31:2], 2'h0};
					n.processor_status_longword.prv = q.processor_status_longword.cur;
					n.processor_status_longword.cur = q.pend_mode;
					n.processor_status_longword.is = q.pend_is;
					n.processor_status_longword.ipl = q.pend_ipl;
					n.vec_rd = 1'b0;
					n.st = pst_pkg::ST_IDLE;
				end
			end
		endcase

		n.sp_sel = n.processor_status_longword.is ? pst_pkg::SP_INTERRUPT
			: {1'b0, n.processor_status_longword.cur};

		// Interlock. A fault or the watchdog drops it, so a trapped
		// instruction cannot starve other processors.
		if (q.lock_held) begin
			n.lock_cnt = q.lock_cnt + 8'h01;
		end
		if (q.lock_held && (lock_i.rel || lock_i.fault
			|| q.lock_cnt == pst_pkg::LOCK_MAX_CYC)) begin
			n.lock_held = 1'b0;
			n.lock_cnt = 8'h00;
		end else if (lock_i.req) begin
			if (q.lock_held) begin
				n.lock_busy = 1'b1;
			end else if ((lock_i.kind == pst_pkg::LK_WORD
				&& lock_i.addr[0])
				|| (lock_i.kind != pst_pkg::LK_BIT
				&& lock_i.kind != pst_pkg::LK_WORD
				&& lock_i.addr[1:0] != 2'h0)) begin
				n.align_fault = 1'b1;
			end else begin
				n.lock_grant = 1'b1;
				n.lock_held = 1'b1;
				n.lock_cnt = 8'h00;
			end
		end

		// Plain accesses never look at the interlock. Each byte has its
		// own enable so neighbours are never rewritten.
		if (mem_i.valid) begin
			n.mem_vld = 1'b1;
			n.mem_be = ((mem_i.size == pst_pkg::SZ_BYTE) ? 4'h1 :
				(mem_i.size == pst_pkg::SZ_WORD) ? 4'h3 : 4'hf)
				<< mem_i.addr[1:0];
			n.io_sel = (mem_i.addr[31:29] == pst_pkg::IO_SPACE_TAG);
		end
	end

	// ***********************************************
	// Registers
	// ***********************************************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '0;
			q.processor_status_longword <= pst_pkg::PSL_RESET;
			q.pc <= pst_pkg::PC_RESET;
			q.scbb <= pst_pkg::SCBB_RESET;
			q.st <= pst_pkg::ST_IDLE;
			q.sp_sel <= pst_pkg::SP_INTERRUPT;
		end else begin
			q <= n;
		end
	end

	assign psl_o = q.processor_status_longword;
	assign pc_o = q.pc;
	assign vec_rd_o = q.vec_rd;
	assign vec_addr_o = q.vec_addr;
	assign irq_ack_o = q.irq_ack;
	assign irq_idx_o = q.irq_idx;
	assign save_vld_o = q.save_vld;
	assign save_pc_o = q.save_pc;
	assign save_psl_o = q.save_psl;
	assign priv_ok_o = q.priv_ok;
	assign priv_fault_o = q.priv_fault;
	assign rei_fault_o = q.rei_fault;
	assign probe_done_o = q.probe_done;
	assign probe_ok_o = q.probe_ok;
	assign sp_sel_o = q.sp_sel;
	assign lock_held_o = q.lock_held;
	assign lock_grant_o = q.lock_grant;
	assign lock_busy_o = q.lock_busy;
	assign align_fault_o = q.align_fault;
	assign mem_be_o = q.mem_be;
	assign io_sel_o = q.io_sel;
	assign mem_vld_o = q.mem_vld;

	// ***********************************************
	// Checks
	// ***********************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_irq_start;
		q.st == pst_pkg::ST_IDLE && !exc_req_i && !chm_req_i
			&& !rei_i && irq_take;
	endsequence
	sequence s_vec_done;
		q.st == pst_pkg::ST_VEC && vec_ack_i;
	endsequence

	chk_flag_carry: assert property (alu_i.valid |=> q.processor_status_longword.c == $past(fl_c))
		else $error("carry flag wrong");
	chk_flag_zero: assert property (alu_i.valid |=>
		q.processor_status_longword.z == ($past(sum[31:0]) == 32'h00000000))
		else $error("zero flag wrong");
	chk_vec_addr: assert property (s_irq_start |=>
		vec_rd_o && vec_addr_o == $past(q.scbb) + $past(irq_off))
		else $error("vector address wrong");
	chk_irq_kernel: assert property (s_irq_start ##2 s_vec_done |=>
		q.processor_status_longword.is && q.processor_status_longword.cur == pst_pkg::MODE_KERNEL
		&& q.processor_status_longword.ipl == $past(q.pend_ipl))
		else $error("interrupt context wrong");
	chk_irq_level: assert property (irq_ack_o |->
		$past(arb_lvl) > $past(q.processor_status_longword.ipl))
		else $error("interrupt taken at low level");
	chk_rei_restore: assert property (q.st == pst_pkg::ST_IDLE && !exc_req_i
		&& !chm_req_i && rei_i && rei_ok |=> pc_o == $past(rei_pc_i))
		else $error("return did not restore");
	chk_mode_lower: assert property (q.processor_status_longword.cur > $past(q.processor_status_longword.cur) |->
		$past(rei_i))
		else $error("privilege lowered without return");
	chk_priv_kernel: assert property (priv_ok_o |->
		$past(q.processor_status_longword.cur) == pst_pkg::MODE_KERNEL)
		else $error("kernel op outside kernel");
	chk_lock_excl: assert property (lock_grant_o |-> !$past(q.lock_held))
		else $error("second interlock granted");
	chk_lock_fault: assert property (q.lock_held && lock_i.fault |=>
		!q.lock_held)
		else $error("interlock kept after fault");
	chk_lock_bound: assert property (q.lock_held
		&& q.lock_cnt == pst_pkg::LOCK_MAX_CYC |=> !q.lock_held)
		else $error("interlock not released");
	chk_sp_select: assert property (q.processor_status_longword.is |->
		sp_sel_o == pst_pkg::SP_INTERRUPT)
		else $error("stack select wrong");

endmodule // pst_core

// *** pst_far_model.sv ***
`timescale 1ns/100ps
module pst_far_model (
	input wire logic clk_i, // Core clock.
	input wire logic vec_rd_i, // Vector read request.
	input wire logic [31:0] vec_addr_i, // Vector address.
	input wire logic [3:0] delay_i, // Extra wait before answering.
	input wire logic [3:0] raise_i, // Controllers wanting service.
	input wire logic irq_ack_i, // Interrupt taken.
	input wire logic [1:0] irq_idx_i, // Source taken.
	output logic vec_ack_o, // Vector data valid.
	output logic [31:0] vec_data_o, // Vector contents.
	output logic [3:0] irq_req_o // Request lines.
);
	logic [3:0] wait_q;

	// Quiet start so the core sees no request before it is ready.
	initial begin
		irq_req_o = 4'h0;
		vec_ack_o = 1'b0;
		vec_data_o = 32'h0;
		wait_q = 4'h0;
	end

	// A controller keeps its request up until the core takes it.
	always @(posedge clk_i) begin
		irq_req_o <= (irq_req_o | raise_i) & ~(4'(irq_ack_i) << irq_idx_i);
	end

	// Vector memory answers after a chosen wait. The low bits of each entry
	// are set, so a core that forgets to drop them lands on a wrong address.
	// Once the answer is taken the data lines stop showing it.
	always @(posedge clk_i) begin
		if (vec_ack_o) begin
			vec_ack_o <= 1'b0;
			vec_data_o <= ~vec_data_o;
			wait_q <= 4'h0;
		end else if (vec_rd_i && wait_q >= delay_i) begin
			vec_ack_o <= 1'b1;
			vec_data_o <= {16'h8000, vec_addr_i[15:0]} | 32'h3;
		end else if (vec_rd_i) begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule // pst_far_model

// *** pst_irq_arb.sv ***
`timescale 1ns/100ps
module pst_irq_arb #(
	parameter int N = 4,
	parameter int LW = 5,
	parameter int IW = 2
) (
	input wire logic [N-1:0] req_i, // Synchronised requests.
	input wire logic [N-1:0] en_i, // Driver enables.
	input wire logic [N*LW-1:0] lvl_i, // Level per source.
	output logic valid_o, // Some source competes.
	output logic [LW-1:0] lvl_o, // Winning level.
	output logic [IW-1:0] idx_o // Winning source.
);
	logic [N-1:0] live;

	// Masking by the driver enable keeps a silenced controller out.
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_mask
			assign live[g] = req_i[g] & en_i[g];
		end
	endgenerate

	// Highest level wins; on a tie the lower index keeps the grant.
	always_comb begin
		valid_o = 1'b0;
		lvl_o = '0;
		idx_o = '0;
		for (int i = 0; i < N; i++) begin
			if (live[i] && (!valid_o || lvl_i[i*LW +: LW] > lvl_o)) begin
				valid_o = 1'b1;
				lvl_o = lvl_i[i*LW +: LW];
				idx_o = IW'(i);
			end
		end
	end
endmodule // pst_irq_arb

// *** pst_pkg.sv ***
package pst_pkg;

	// ***********************************************
	// Constants
	// ***********************************************
	localparam int PSW_W = 16;
	localparam logic [31:0] PSL_RESET = 32'h041f0000;
	localparam logic [31:0] PC_RESET = 32'h00000000;
	localparam logic [31:0] SCBB_RESET = 32'h00000000;
	localparam logic [31:0] IRQ_VEC_BASE = 32'h00000100;
	localparam logic [31:0] CHM_VEC_BASE = 32'h00000040;
	localparam logic [2:0] IO_SPACE_TAG = 3'h7;
	localparam logic [7:0] LOCK_MAX_CYC = 8'hff;
	localparam logic [2:0] SP_INTERRUPT = 3'h4;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] LK_BIT = 2'h0;
	localparam logic [1:0] LK_WORD = 2'h1;

	// ***********************************************
	// Types
	// ***********************************************
	typedef enum logic [1:0] {
		MODE_KERNEL = 2'b00,
		MODE_EXEC = 2'b01,
		MODE_SUPER = 2'b10,
		MODE_USER = 2'b11
	} pst_mode_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_VEC = 1'b1
	} pst_fsm_t;

	typedef struct packed {
		logic [4:0] rsv_hi;
		logic is;
		pst_mode_t cur;
		pst_mode_t prv;
		logic rsv_mid;
		logic [4:0] ipl;
		logic [11:0] rsv_lo;
		logic n;
		logic z;
		logic v;
		logic c;
	} pst_psl_t;

	typedef struct packed {
		logic valid;
		logic sub;
		logic [1:0] size;
		logic conv_err;
		logic [31:0] a;
		logic [31:0] b;
	} pst_alu_t;

	typedef struct packed {
		logic req;
		logic rel;
		logic fault;
		logic [1:0] kind;
		logic [31:0] addr;
	} pst_lock_t;

	typedef struct packed {
		logic valid;
		logic [1:0] size;
		logic [31:0] addr;
	} pst_mem_t;

endpackage

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	// ***********************************************
	// Signals
	// ***********************************************
	logic clk_i, reset_n_i, psw_wr_i, exc_req_i, chm_req_i, vec_ack_i;
	logic rei_i, priv_op_i, scbb_wr_i, probe_i, vec_rd_o, irq_ack_o;
	logic save_vld_o, priv_ok_o, priv_fault_o, rei_fault_o, probe_done_o;
	logic probe_ok_o, lock_held_o, lock_grant_o, lock_busy_o;
	logic align_fault_o, io_sel_o, mem_vld_o;
	logic [15:0] psw_data_i;
	logic [8:0] exc_off_i;
	logic [3:0] irq_req_i, irq_en_i, raise, delay, mem_be_o;
	logic [19:0] irq_lvl_i;
	logic [31:0] vec_data_i, rei_pc_i, scbb_data_i, vec_addr_o, pc_o;
	logic [31:0] save_pc_o;
	logic [1:0] irq_idx_o;
	logic [2:0] sp_sel_o;
	pst_pkg::pst_mode_t chm_mode_i, probe_min_i;
	pst_pkg::pst_alu_t alu_i;
	pst_pkg::pst_psl_t rei_psl_i, psl_o, save_psl_o;
	pst_pkg::pst_lock_t lock_i;
	pst_pkg::pst_mem_t mem_i;
	int n_errors, checked, cyc;

	pst_core i_dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .alu_i(alu_i),
		.psw_wr_i(psw_wr_i), .psw_data_i(psw_data_i), .exc_req_i(exc_req_i),
		.exc_off_i(exc_off_i), .chm_req_i(chm_req_i), .chm_mode_i(chm_mode_i),
		.irq_req_i(irq_req_i), .irq_en_i(irq_en_i), .irq_lvl_i(irq_lvl_i),
		.vec_ack_i(vec_ack_i), .vec_data_i(vec_data_i), .rei_i(rei_i),
		.rei_pc_i(rei_pc_i), .rei_psl_i(rei_psl_i), .priv_op_i(priv_op_i),
		.scbb_wr_i(scbb_wr_i), .scbb_data_i(scbb_data_i), .probe_i(probe_i),
		.probe_min_i(probe_min_i), .lock_i(lock_i), .mem_i(mem_i),
		.psl_o(psl_o), .pc_o(pc_o), .vec_rd_o(vec_rd_o),
		.vec_addr_o(vec_addr_o), .irq_ack_o(irq_ack_o),
		.irq_idx_o(irq_idx_o), .save_vld_o(save_vld_o),
		.save_pc_o(save_pc_o), .save_psl_o(save_psl_o),
		.priv_ok_o(priv_ok_o), .priv_fault_o(priv_fault_o),
		.rei_fault_o(rei_fault_o), .probe_done_o(probe_done_o),
		.probe_ok_o(probe_ok_o), .sp_sel_o(sp_sel_o),
		.lock_held_o(lock_held_o), .lock_grant_o(lock_grant_o),
		.lock_busy_o(lock_busy_o), .align_fault_o(align_fault_o),
		.mem_be_o(mem_be_o), .io_sel_o(io_sel_o), .mem_vld_o(mem_vld_o)
	);

	pst_far_model i_far (
		.clk_i(clk_i), .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o),
		.delay_i(delay), .raise_i(raise), .irq_ack_i(irq_ack_o),
		.irq_idx_i(irq_idx_o), .vec_ack_o(vec_ack_i),
		.vec_data_o(vec_data_i), .irq_req_o(irq_req_i)
	);

	// ***********************************************
	// Clock, watchdog and shared tasks
	// ***********************************************
	// The clock runs at 25 MHz.
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// A hung handshake would stall the run, so cut it short here.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Waits for the vector read, then for the handler entry.
	task automatic dispatch(input logic [31:0] va);
		int k;
		k = 0;
		while (vec_rd_o !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		chk(vec_addr_o, va, "vector address");
		k = 0;
		while (save_vld_o !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		chk(pc_o, {16'h8000, va[15:0]}, "handler address");
	endtask

	task automatic alu(input logic sub, input logic [1:0] sz, input logic cv,
		input logic [31:0] a, input logic [31:0] b, input logic [3:0] nzvc);
		alu_i = '{1'b1, sub, sz, cv, a, b};
		tick(1);
		alu_i.valid = 1'b0;
		chk(32'(psl_o[3:0]), 32'(nzvc), "flags");
		// An idle edge keeps the next call from raising a dropped strobe.
		tick(1);
	endtask

	task automatic probe(input pst_pkg::pst_mode_t m, input logic ok);
		probe_min_i = m;
		probe_i = 1'b1;
		tick(1);
		probe_i = 1'b0;
		chk(32'({probe_done_o, probe_ok_o}), 32'({1'b1, ok}), "probe");
		tick(1);
	endtask

	task automatic wait_irq(input logic [1:0] idx, input logic [31:0] va,
		input logic [7:0] ctx);
		int k;
		k = 0;
		while (irq_ack_o !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		chk(32'(irq_idx_o), 32'(idx), "source taken");
		dispatch(va);
		chk(32'({psl_o.is, psl_o.cur, psl_o.ipl}), 32'(ctx), "irq ctx");
		chk(32'(sp_sel_o), 32'h4, "interrupt stack");
	endtask

	// The result bits are {grant, busy, align fault, held}.
	task automatic lk(input logic [2:0] rrf, input logic [1:0] kind,
		input logic [31:0] a, input logic [3:0] exp);
		lock_i = '{rrf[2], rrf[1], rrf[0], kind, a};
		tick(1);
		lock_i = '0;
		chk(32'({lock_grant_o, lock_busy_o, align_fault_o, lock_held_o}),
			32'(exp), "interlock");
		tick(1);
	endtask

	task automatic mem(input logic [1:0] sz, input logic [31:0] a,
		input logic [4:0] exp);
		mem_i = '{1'b1, sz, a};
		tick(1);
		mem_i = '0;
		chk(32'({mem_vld_o, io_sel_o, mem_be_o}), 32'({1'b1, exp}),
			"access");
		tick(1);
	endtask

	// ***********************************************
	// Main sequence
	// ***********************************************
	initial begin
		{reset_n_i, psw_wr_i, exc_req_i, chm_req_i, rei_i} = '0;
		{priv_op_i, scbb_wr_i, probe_i, psw_data_i, exc_off_i} = '0;
		{irq_en_i, raise, delay, irq_lvl_i, rei_pc_i, scbb_data_i} = '0;
		{n_errors, checked, cyc} = '0;
		chm_mode_i = pst_pkg::MODE_KERNEL;
		probe_min_i = pst_pkg::MODE_KERNEL;
		{alu_i, rei_psl_i, lock_i, mem_i} = '0;
		tick(2);
		reset_n_i = 1'b1;
		tick(1);
		chk(psl_o, 32'h041f0000, "reset status");
		chk(32'(sp_sel_o), 32'h4, "reset stack");
		// Carry, borrow, overflow and zero over all operand sizes.
		alu(1'b0, 2'h2, 1'b0, 32'hffffffff, 32'h1, 4'b0101);
		alu(1'b1, 2'h2, 1'b0, 32'h1, 32'h2, 4'b1001);
		alu(1'b0, 2'h2, 1'b0, 32'h7fffffff, 32'h1, 4'b1010);
		alu(1'b0, 2'h0, 1'b0, 32'h7f, 32'h1, 4'b1010);
		alu(1'b0, 2'h1, 1'b0, 32'h8000, 32'h8000, 4'b0111);
		alu(1'b0, 2'h2, 1'b1, 32'h1, 32'h1, 4'b0010);
		alu(1'b1, 2'h0, 1'b0, 32'h5, 32'h5, 4'b0100);
		// Kernel operations are allowed after reset.
		priv_op_i = 1'b1;
		tick(1);
		priv_op_i = 1'b0;
		chk(32'(priv_ok_o), 32'h1, "kernel op");
		scbb_data_i = 32'h00002000;
		scbb_wr_i = 1'b1;
		tick(1);
		scbb_wr_i = 1'b0;
		chk(32'(priv_ok_o), 32'h1, "base write");
		// Exception with a slow vector answer.
		delay = 4'h4;
		exc_off_i = 9'h020;
		exc_req_i = 1'b1;
		tick(1);
		exc_req_i = 1'b0;
		dispatch(32'h00002020);
		chk(save_pc_o, 32'h0, "saved counter");
		chk(save_psl_o, 32'h041f0004, "saved status");
		// Return lowers to user mode; a return that raises it is refused.
		rei_pc_i = 32'h00000400;
		rei_psl_i = 32'h03c00005;
		rei_i = 1'b1;
		tick(1);
		rei_i = 1'b0;
		chk(pc_o, 32'h400, "return counter");
		chk(psl_o, 32'h03c00005, "return status");
		chk(32'(sp_sel_o), 32'h3, "user stack");
		tick(1);
		rei_psl_i = 32'h0;
		rei_i = 1'b1;
		tick(1);
		rei_i = 1'b0;
		chk(32'(rei_fault_o), 32'h1, "raise refused");
		chk(psl_o, 32'h03c00005, "status kept");
		psw_data_i = 16'h000a;
		psw_wr_i = 1'b1;
		tick(1);
		psw_wr_i = 1'b0;
		chk(psl_o, 32'h03c0000a, "user word");
		priv_op_i = 1'b1;
		tick(1);
		priv_op_i = 1'b0;
		chk(32'(priv_fault_o), 32'h1, "user op");
		probe(pst_pkg::MODE_EXEC, 1'b0);
		probe(pst_pkg::MODE_USER, 1'b1);
		// Change mode trap with a prompt vector answer.
		delay = 4'h0;
		chm_mode_i = pst_pkg::MODE_EXEC;
		chm_req_i = 1'b1;
		tick(1);
		chm_req_i = 1'b0;
		dispatch(32'h00002044);
		chk(32'(psl_o.cur), 32'h1, "trap mode");
		// Source 1 is disabled, so source 2 must win.
		irq_lvl_i = {5'd0, 5'd5, 5'd9, 5'd3};
		irq_en_i = 4'b0101;
		raise = 4'b0110;
		tick(1);
		raise = 4'h0;
		wait_irq(2'h2, 32'h00002108, 8'h85);
		raise = 4'b0001;
		tick(1);
		raise = 4'h0;
		tick(10);
		chk(32'(vec_rd_o), 32'h0, "lower level held");
		irq_en_i = 4'b0111;
		wait_irq(2'h1, 32'h00002104, 8'h89);
		irq_en_i = 4'h0;
		// Interlocks, with plain accesses passing a held lock.
		lk(3'b100, pst_pkg::LK_BIT, 32'h103, 4'b1001);
		lk(3'b100, pst_pkg::LK_WORD, 32'h200, 4'b0101);
		mem(pst_pkg::SZ_BYTE, 32'h101, 5'b00010);
		lk(3'b010, 2'h0, 32'h0, 4'b0000);
		lk(3'b100, pst_pkg::LK_WORD, 32'h201, 4'b0010);
		lk(3'b100, pst_pkg::LK_WORD, 32'h202, 4'b1001);
		lk(3'b001, 2'h0, 32'h0, 4'b0000);
		lk(3'b100, 2'h2, 32'h302, 4'b0010);
		lk(3'b100, 2'h3, 32'h300, 4'b1001);
		lk(3'b010, 2'h0, 32'h0, 4'b0000);
		// A lock left alone is dropped by the watchdog after 256 edges.
		lk(3'b100, pst_pkg::LK_BIT, 32'h0, 4'b1001);
		tick(254);
		chk(32'(lock_held_o), 32'h1, "lock before limit");
		tick(1);
		chk(32'(lock_held_o), 32'h0, "lock watchdog");
		mem(pst_pkg::SZ_WORD, 32'h2, 5'b01100);
		mem(2'h2, 32'he0000010, 5'b11111);
		mem(pst_pkg::SZ_BYTE, 32'he0000003, 5'b11000);
		end_of_test();
	end
endmodule // tb_top
